// *** lbc_consts.svh ***
// constants for the logic, bit and call execute block
`ifndef LBC_CONSTS_SVH
`define LBC_CONSTS_SVH

// instruction word layout
`define LBC_IW_W        13
`define LBC_PC_W        10
`define LBC_DW          8
`define LBC_FA_W        6

// opcode fields
`define LBC_OP6_AND     6'h04
`define LBC_OP5_ANDI    5'h1c
`define LBC_OP4_BCLR    4'h4
`define LBC_OP4_BSET    4'h5
`define LBC_OP4_TSTZ    4'h6
`define LBC_OP4_TSTO    4'h7
`define LBC_OP3_CALL    3'h6

// field positions
`define LBC_DEST_POS    6
`define LBC_BIT_HI      8
`define LBC_BIT_LO      6
`define LBC_FA_HI       5
`define LBC_IMM_HI      7
`define LBC_TGT_HI      9

// reset values
`define LBC_PC_RST      10'h000
`define LBC_WREG_RST    8'h00
`define LBC_ZERO_RST    1'b0

// cycle figures
`define LBC_SKIP_CYC    2
`define LBC_CALL_CYC    2

`endif

// *** lbc_core.sv ***
// execute stage for and, bit clear/set, bit test skip and call
`timescale 1ns/10ps
`include "lbc_consts.svh"

// Overview of operation
// - A file-operand and with destination bit 0 puts working_register and file into working_register and sets zero.
// - A file-operand and with destination bit 1 writes the result back to the file register in one cycle.
// - The immediate and combines working_register with the 8-bit constant in one cycle and sets zero.
// - The immediate and always lands in working_register and never in a file register.
// - bit_clear_in_file clears bit 0..7 of file 0..0x3f in one cycle with flags unchanged.
// - bit_set_in_file sets the chosen bit of the file in one cycle with flags unchanged.
// - test_bit_skip_if_zero skips the next instruction when the bit is zero, flags unchanged.
// - On that skip the prefetched word becomes a no-operation, so it takes 2 cycles, else 1.
// - test_bit_skip_if_one skips the next instruction when the bit is one, flags unchanged.
// - On that skip the prefetched word becomes a no-operation, so it takes 2 cycles, else 1.
// - A call first pushes the address after the call onto the return stack.
// - A call then loads its 10-bit target into program counter bits 9..0, flags unchanged.
// - A call takes exactly two cycles, the second flushing the sequential fetch.
module lbc_core #(
  parameter int STACK_DEPTH = 4,
  parameter int FILE_DEPTH  = 64
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [`LBC_IW_W-1:0]      prog_word,
  output logic      [`LBC_PC_W-1:0]      prog_addr,
  output logic      [`LBC_DW-1:0]        working_register,
  output logic                           zero_flag,
  output logic      [`LBC_PC_W-1:0]      stack_top,
  output logic      [$clog2(STACK_DEPTH+1)-1:0] stack_level,
  output logic                           nop_cycle
);

  localparam int LW = $clog2(STACK_DEPTH + 1);
  localparam logic [LW-1:0] LVL_MAX = LW'(STACK_DEPTH);

  lbc_pkg::lbc_dec_t   dec;
  lbc_pkg::lbc_dec_t   next_dec;
  lbc_pkg::lbc_wr_t    wr;
  logic [`LBC_PC_W-1:0] pc;
  logic [`LBC_PC_W-1:0] next_pc;
  logic [`LBC_DW-1:0]   wreg;
  logic [`LBC_DW-1:0]   next_wreg;
  logic                 zero;
  logic                 next_zero;
  logic                 flush;
  logic                 next_flush;
  logic                 push;
  logic [LW-1:0]        level;
  logic [LW-1:0]        next_level;
  logic [`LBC_DW-1:0]   rdata;
  logic [`LBC_DW-1:0]   and_res;
  logic [`LBC_DW-1:0]   andi_res;
  logic [`LBC_DW-1:0]   bit_mask;
  logic                 bit_val;
  logic [`LBC_PC_W-1:0] stack      [STACK_DEPTH];
  logic [`LBC_PC_W-1:0] next_stack [STACK_DEPTH];

  // decode of the word being fetched
  always_comb begin
    next_dec           = '0;
    next_dec.op        = lbc_pkg::lbc_op_nop;
    next_dec.dest_file = prog_word[`LBC_DEST_POS];
    next_dec.bit_sel   = prog_word[`LBC_BIT_HI:`LBC_BIT_LO];
    next_dec.fadr      = prog_word[`LBC_FA_HI:0];
    next_dec.imm       = prog_word[`LBC_IMM_HI:0];
    next_dec.target    = prog_word[`LBC_TGT_HI:0];
    if (prog_word[12:7] == `LBC_OP6_AND) begin
      next_dec.op = lbc_pkg::lbc_op_and;
    end else if (prog_word[12:8] == `LBC_OP5_ANDI) begin
      next_dec.op = lbc_pkg::lbc_op_andi;
    end else if (prog_word[12:10] == `LBC_OP3_CALL) begin
      next_dec.op = lbc_pkg::lbc_op_call;
    end else if (prog_word[12:9] == `LBC_OP4_BCLR) begin
      next_dec.op = lbc_pkg::lbc_op_bclr;
    end else if (prog_word[12:9] == `LBC_OP4_BSET) begin
      next_dec.op = lbc_pkg::lbc_op_bset;
    end else if (prog_word[12:9] == `LBC_OP4_TSTZ) begin
      next_dec.op = lbc_pkg::lbc_op_tstz;
    end else if (prog_word[12:9] == `LBC_OP4_TSTO) begin
      next_dec.op = lbc_pkg::lbc_op_tsto;
    end
  end

  lbc_file_mem #(
    .DEPTH (FILE_DEPTH)
  ) u_mem (
    .clk   (clk),
    .wr    (wr),
    .raddr (next_dec.fadr),
    .rdata (rdata)
  );

  assign and_res  = wreg & rdata;
  assign andi_res = wreg & dec.imm;
  assign bit_mask = 8'h01 << dec.bit_sel;
  assign bit_val  = rdata[dec.bit_sel];

  // execute
  always_comb begin
    next_pc    = pc + 10'h001;
    next_flush = 1'b0;
    next_wreg  = wreg;
    next_zero  = zero;
    wr         = '0;
    push       = 1'b0;
    if (!flush) begin
      unique case (dec.op)
        lbc_pkg::lbc_op_nop: begin
        end
        lbc_pkg::lbc_op_and: begin
          if (dec.dest_file) begin
            wr = '{en: 1'b1, addr: dec.fadr, data: and_res};
          end else begin
            next_wreg = and_res;
          end
          next_zero = (and_res == 8'h00);
        end
        lbc_pkg::lbc_op_andi: begin
          next_wreg = andi_res;
          next_zero = (andi_res == 8'h00);
        end
        lbc_pkg::lbc_op_bclr: begin
          wr = '{en: 1'b1, addr: dec.fadr, data: rdata & ~bit_mask};
        end
        lbc_pkg::lbc_op_bset: begin
          wr = '{en: 1'b1, addr: dec.fadr, data: rdata | bit_mask};
        end
        lbc_pkg::lbc_op_tstz: begin
          next_flush = ~bit_val;
        end
        lbc_pkg::lbc_op_tsto: begin
          next_flush = bit_val;
        end
        lbc_pkg::lbc_op_call: begin
          push       = 1'b1;
          next_pc    = dec.target;
          next_flush = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc    <= `LBC_PC_RST;
      wreg  <= `LBC_WREG_RST;
      zero  <= `LBC_ZERO_RST;
      flush <= 1'b0;
      dec   <= '{op: lbc_pkg::lbc_op_nop, default: '0};
    end else begin
      pc    <= next_pc;
      wreg  <= next_wreg;
      zero  <= next_zero;
      flush <= next_flush;
      dec   <= next_dec;
    end
  end

  // return stack, entry 0 is the top; oldest entry falls off when full
  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stk
      if (gi == 0) begin : g_top
        assign next_stack[gi] = push ? pc : stack[gi];
      end else begin : g_deep
        assign next_stack[gi] = push ? stack[gi-1] : stack[gi];
      end
    end
  endgenerate

  always_comb begin
    next_level = level;
    if (push && (level != LVL_MAX)) begin
      next_level = level + LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level <= '0;
      for (int k = 0; k < STACK_DEPTH; k++) begin
        stack[k] <= `LBC_PC_RST;
      end
    end else begin
      level <= next_level;
      for (int k = 0; k < STACK_DEPTH; k++) begin
        stack[k] <= next_stack[k];
      end
    end
  end

  assign prog_addr        = pc;
  assign working_register = wreg;
  assign zero_flag        = zero;
  assign stack_top        = stack[0];
  assign stack_level      = level;
  assign nop_cycle        = flush;

  // checks
  property p_and_to_wreg;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_and && !dec.dest_file) |=>
      (wreg == $past(and_res)) && (zero == ($past(and_res) == 8'h00));
  endproperty
  a_and_to_wreg: assert property (p_and_to_wreg)
    else $error("and to working register wrong");

  property p_and_to_file;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_and && dec.dest_file) |->
      wr.en && (wr.addr == dec.fadr) && (wr.data == (wreg & rdata)) ##1 $stable(wreg) && !flush;
  endproperty
  a_and_to_file: assert property (p_and_to_file)
    else $error("and to file register wrong");

  property p_andi;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_andi) |=>
      (wreg == ($past(wreg) & $past(dec.imm))) && (zero == (wreg == 8'h00));
  endproperty
  a_andi: assert property (p_andi)
    else $error("immediate and wrong");

  property p_andi_no_file;
    @(posedge clk) disable iff (!rst_b)
    (dec.op == lbc_pkg::lbc_op_andi) |-> !wr.en;
  endproperty
  a_andi_no_file: assert property (p_andi_no_file)
    else $error("immediate and wrote a file register");

  property p_bclr;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_bclr) |->
      wr.en && !wr.data[dec.bit_sel] && ((wr.data | bit_mask) == (rdata | bit_mask))
      ##1 $stable(zero) && $stable(wreg);
  endproperty
  a_bclr: assert property (p_bclr)
    else $error("bit clear wrong");

  property p_bset;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_bset) |->
      wr.en && wr.data[dec.bit_sel] && ((wr.data & ~bit_mask) == (rdata & ~bit_mask))
      ##1 $stable(zero) && $stable(wreg);
  endproperty
  a_bset: assert property (p_bset)
    else $error("bit set wrong");

  property p_tstz;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_tstz) |->
      !wr.en ##1 (flush == !$past(bit_val)) && $stable(zero);
  endproperty
  a_tstz: assert property (p_tstz)
    else $error("skip if zero decision wrong");

  property p_tstz_len;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_tstz && !bit_val) |=>
      flush && (pc == $past(pc) + 10'h001) ##1 !flush;
  endproperty
  a_tstz_len: assert property (p_tstz_len)
    else $error("skip if zero length wrong");

  property p_tsto;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_tsto) |->
      !wr.en ##1 (flush == $past(bit_val)) && $stable(zero);
  endproperty
  a_tsto: assert property (p_tsto)
    else $error("skip if one decision wrong");

  property p_tsto_len;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_tsto && bit_val) |=>
      flush && (pc == $past(pc) + 10'h001) ##1 !flush;
  endproperty
  a_tsto_len: assert property (p_tsto_len)
    else $error("skip if one length wrong");

  property p_call_push;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_call) |=> (stack_top == $past(pc));
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call pushed wrong return address");

  property p_call_target;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_call) |=>
      (pc == $past(dec.target)) && $stable(zero);
  endproperty
  a_call_target: assert property (p_call_target)
    else $error("call target wrong");

  property p_call_len;
    @(posedge clk) disable iff (!rst_b)
    (!flush && dec.op == lbc_pkg::lbc_op_call) |=>
      flush ##1 !flush && (pc == $past(pc) + 10'h001);
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("call length wrong");

  property p_flush_quiet;
    @(posedge clk) disable iff (!rst_b)
    flush |-> !wr.en && !push ##1 $stable(wreg) && $stable(zero) && $stable(level);
  endproperty
  a_flush_quiet: assert property (p_flush_quiet)
    else $error("no-operation cycle changed state");

endmodule

// *** lbc_file_mem.sv ***
// file register memory, write-first, registered read data
`timescale 1ns/10ps
`include "lbc_consts.svh"

module lbc_file_mem #(
  parameter int DEPTH = 64
) (
  input  wire logic                    clk,
  input  wire lbc_pkg::lbc_wr_t        wr,
  input  wire logic [`LBC_FA_W-1:0]    raddr,
  output logic      [`LBC_DW-1:0]      rdata
);

  logic [`LBC_DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // a write to the address being read is forwarded
  always_ff @(posedge clk) begin
    if (wr.en && (wr.addr == raddr)) begin
      rdata <= wr.data;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// *** lbc_pkg.sv ***
// types for the logic, bit and call execute block
package lbc_pkg;

  typedef enum logic [7:0] {
    lbc_op_nop  = 8'h01,
    lbc_op_and  = 8'h02,
    lbc_op_andi = 8'h04,
    lbc_op_bclr = 8'h08,
    lbc_op_bset = 8'h10,
    lbc_op_tstz = 8'h20,
    lbc_op_tsto = 8'h40,
    lbc_op_call = 8'h80
  } lbc_op_t;

  typedef struct packed {
    lbc_op_t    op;
    logic       dest_file;
    logic [2:0] bit_sel;
    logic [5:0] fadr;
    logic [7:0] imm;
    logic [9:0] target;
  } lbc_dec_t;

  typedef struct packed {
    logic       en;
    logic [5:0] addr;
    logic [7:0] data;
  } lbc_wr_t;

endpackage

// *** lbc_tb.sv ***
// self-checking testbench for the logic, bit and call execute core
`timescale 1ns/10ps
`include "lbc_consts.svh"

module tb;
  logic        clk;
  logic        rst_b;
  logic [12:0] prog_word;
  logic [9:0]  prog_addr;
  logic [7:0]  working_register;
  logic        zero_flag;
  logic [9:0]  stack_top;
  logic [2:0]  stack_level;
  logic        nop_cycle;
  logic [12:0] rom [0:1023];
  int          errors;
  int          num_checks;
  int          nops;

  lbc_core #(
    .STACK_DEPTH (4),
    .FILE_DEPTH  (64)
  ) u_dut (
    .clk              (clk),
    .rst_b            (rst_b),
    .prog_word        (prog_word),
    .prog_addr        (prog_addr),
    .working_register (working_register),
    .zero_flag        (zero_flag),
    .stack_top        (stack_top),
    .stack_level      (stack_level),
    .nop_cycle        (nop_cycle)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // program memory answers the fetch address; discarded cycles counted out of reset
  always @(negedge clk) begin
    prog_word <= rom[prog_addr];
    if (rst_b !== 1'b1) nops = 0;
    else if (nop_cycle === 1'b1) nops++;
  end

  function automatic logic [12:0] wb(input logic [3:0] op, input logic [2:0] b,
                                     input logic [5:0] r);
    wb = {op, b, r};
  endfunction

  function automatic logic [12:0] wa(input logic d, input logic [5:0] r);
    wa = {`LBC_OP6_AND, d, r};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_pc(input logic [9:0] p);
    int i;
    for (i = 0; i < 64 && prog_addr !== p; i++) @(negedge clk);
    if (prog_addr !== p) begin
      errors++;
      $display("mismatch prog_addr expected %h seen %h", p, prog_addr);
      wrap_up();
    end
  endtask

  // new program must be in place one falling edge before the first fetch
  task automatic release_reset;
    @(negedge clk);
    rst_b = 1'b1;
  endtask

  // holds reset, checks cleared state, leaves reset asserted with an empty program
  task automatic do_reset;
    int i;
    rst_b = 1'b0;
    for (i = 0; i < 1024; i++) rom[i] = 13'h0000;
    repeat (6) @(negedge clk);
    chk("prog_addr", 16'h0000, {6'h00, prog_addr});
    chk("working_register", 16'h0000, {8'h00, working_register});
    chk("zero_flag", 16'h0000, {15'h0000, zero_flag});
    chk("stack_top", 16'h0000, {6'h00, stack_top});
    chk("stack_level", 16'h0000, {13'h0000, stack_level});
    chk("nop_cycle", 16'h0000, {15'h0000, nop_cycle});
  endtask

  task automatic sc_bits_skip_call;
    do_reset();
    // and with the cleared working register gives file 0x3f a known value
    rom[0]  = wa(1'b1, 6'h3f);
    rom[1]  = wb(`LBC_OP4_BSET, 3'h7, 6'h3f);
    rom[2]  = wb(`LBC_OP4_BCLR, 3'h0, 6'h3f);
    rom[3]  = wb(`LBC_OP4_TSTO, 3'h7, 6'h3f);
    rom[4]  = {`LBC_OP3_CALL, 10'h3ff};
    rom[5]  = wb(`LBC_OP4_TSTZ, 3'h0, 6'h3f);
    rom[6]  = {`LBC_OP3_CALL, 10'h3ff};
    rom[7]  = wb(`LBC_OP4_TSTZ, 3'h7, 6'h3f);
    rom[8]  = wb(`LBC_OP4_TSTO, 3'h0, 6'h3f);
    rom[9]  = wa(1'b1, 6'h3f);
    rom[10] = wb(`LBC_OP4_TSTZ, 3'h7, 6'h3f);
    rom[11] = {`LBC_OP3_CALL, 10'h3ff};
    rom[12] = wa(1'b0, 6'h3f);
    rom[13] = {`LBC_OP5_ANDI, 8'hff};
    rom[14] = {`LBC_OP3_CALL, 10'h020};
    rom[15] = {`LBC_OP3_CALL, 10'h3ff};
    release_reset();
    wait_pc(10'd2);
    chk("zero_flag", 16'h0001, {15'h0000, zero_flag});
    wait_pc(10'd10);
    chk("zero_flag", 16'h0001, {15'h0000, zero_flag});
    chk("stack_level", 16'h0000, {13'h0000, stack_level});
    wait_pc(10'd11);
    chk("zero_flag", 16'h0001, {15'h0000, zero_flag});
    wait_pc(10'd15);
    chk("stack_level", 16'h0000, {13'h0000, stack_level});
    wait_pc(10'h020);
    chk("stack_top", 16'h000f, {6'h00, stack_top});
    chk("stack_level", 16'h0001, {13'h0000, stack_level});
    chk("nop_cycle", 16'h0001, {15'h0000, nop_cycle});
    @(negedge clk);
    chk("prog_addr", 16'h0021, {6'h00, prog_addr});
    chk("nop_cycle", 16'h0000, {15'h0000, nop_cycle});
    #1;
    chk("discarded cycles", 16'h0004, nops[15:0]);
    chk("working_register", 16'h0000, {8'h00, working_register});
  endtask

  // file 0x3f bit 7 survives an immediate whose low bits alias that address
  task automatic sc_and_immediate;
    do_reset();
    rom[0] = wb(`LBC_OP4_BSET, 3'h7, 6'h3f);
    rom[1] = {`LBC_OP5_ANDI, 8'h3f};
    rom[2] = wb(`LBC_OP4_TSTO, 3'h7, 6'h3f);
    rom[3] = {`LBC_OP3_CALL, 10'h3ff};
    release_reset();
    wait_pc(10'd2);
    chk("zero_flag", 16'h0000, {15'h0000, zero_flag});
    wait_pc(10'd3);
    chk("zero_flag", 16'h0001, {15'h0000, zero_flag});
    chk("working_register", 16'h0000, {8'h00, working_register});
    wait_pc(10'd6);
    chk("stack_level", 16'h0000, {13'h0000, stack_level});
  endtask

  // file 0x3f still holds 0x80 from the previous scenario
  task automatic sc_and_file_to_working;
    do_reset();
    rom[0] = wa(1'b0, 6'h3f);
    rom[1] = wb(`LBC_OP4_TSTO, 3'h7, 6'h3f);
    rom[2] = {`LBC_OP3_CALL, 10'h3ff};
    release_reset();
    wait_pc(10'd2);
    chk("zero_flag", 16'h0001, {15'h0000, zero_flag});
    chk("working_register", 16'h0000, {8'h00, working_register});
    wait_pc(10'd5);
    chk("stack_level", 16'h0000, {13'h0000, stack_level});
  endtask

  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    @(negedge clk);
    sc_bits_skip_call();
    sc_and_immediate();
    sc_and_file_to_working();
    wrap_up();
  end
endmodule
